// file: hdl/fspc_ctrl.sv
// Flash self-programming controller top: mode, commands, timing, flash array
// How it works
// - HALT starts operation only in self mode
// - Run loaded command, then release HALT
// - Maskable interrupts blocked in self mode
// - Block verify ends within 6.8 ms
// - Byte verify takes 27 us per verify_count (0 counts as 1)
// - Block erase of loaded block, 8.5 ms
// - Erased bytes read FFH
// - Blank check of loaded block, 480 us
// - Byte write completes in 150 us
// - CPU stalls; software restarts watchdog first
// - Interrupts pend; software masks beforehand
// - Entry HALT released within 10 us plus 2
// - Pins held as in HALT standby
// - Only protect byte blocks write or erase
// - Protect byte at 0081H read in mode bits
// - Mode bit changes only via unlock; protect bits follow 0081H
// - Mode register sets mode, shows protect
// - Unlock: A5H, value, inverse, value
// - Mode bit 0 cleared at reset
// - Bad sequence sets status bit 0
// - Verify error bit 1, protect bit 2
`timescale 1ns/1ps
module fspc_ctrl (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire fspc_pkg::fspc_store_t store,
  input  wire logic [15:0]        flash_addr_pointer,
  input  wire logic [7:0]         flash_write_buffer,
  input  wire logic [7:0]         verify_count,
  input  wire logic               halt_exec,
  input  wire logic               irq_request,
  input  wire logic [15:0]        read_addr,
  output logic [7:0]              read_data,
  output logic                    halt_release,
  output logic                    cpu_stalled,
  output logic                    irq_accept,
  output logic                    pins_standby,
  output logic [7:0]              flash_mode_control_reg,
  output logic [7:0]              flash_error_status_reg,
  output logic [7:0]              flash_operation_command_reg
);
  // Small model array: 256 bytes, blocks of 64; address uses low byte
  localparam int BLK_BYTES = 64;
  localparam int NBLK      = 4;

  logic [7:0]  mem_reg [0:255];
  logic        mode_we;
  logic        seq_error;
  logic        self_mode_reg;
  logic        self_mode_next;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  fspc_pkg::fspc_state_t state_reg;
  fspc_pkg::fspc_state_t state_next;
  logic [fspc_pkg::TMR_W-1:0] tmr_reg;
  logic [fspc_pkg::TMR_W-1:0] tmr_next;
  logic [7:0]  op_addr_reg;
  logic [7:0]  op_addr_next;
  logic [7:0]  op_data_reg;
  logic [7:0]  op_data_next;
  logic        release_reg;
  logic        release_next;
  logic        mismatch;
  logic        not_blank;
  logic        do_erase;
  logic        do_write;
  logic [4:0]  protect_bits;
  logic        blk_protected;
  logic [1:0]  op_blk;

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c >= fspc_pkg::CMD_VERIFY_BLK) && (c <= fspc_pkg::CMD_BYTE_WRITE);
  endfunction

  function automatic logic [fspc_pkg::TMR_W-1:0] cmd_cycles(input logic [7:0] c,
                                                           input logic [7:0] n);
    case (c)
      fspc_pkg::CMD_VERIFY_BLK:  cmd_cycles = fspc_pkg::TMR_W'(fspc_pkg::CYC_VERIFY_BLK);
      fspc_pkg::CMD_VERIFY_BYTE: cmd_cycles = fspc_pkg::TMR_W'(fspc_pkg::CYC_VERIFY_BYTE
                                                              * ((n == 8'h00) ? 1 : int'(n)));
      fspc_pkg::CMD_ERASE_BLK:   cmd_cycles = fspc_pkg::TMR_W'(fspc_pkg::CYC_ERASE);
      fspc_pkg::CMD_BLANK_CHK:   cmd_cycles = fspc_pkg::TMR_W'(fspc_pkg::CYC_BLANK);
      fspc_pkg::CMD_BYTE_WRITE:  cmd_cycles = fspc_pkg::TMR_W'(fspc_pkg::CYC_WRITE);
      default:                   cmd_cycles = '0;
    endcase
  endfunction

  fspc_unlock u_unlock (
    .core_clk  (core_clk),
    .rst       (rst),
    .store     (store),
    .mode_we   (mode_we),
    .seq_error (seq_error)
  );

  assign protect_bits  = mem_reg[fspc_pkg::PROTECT_ADDR[7:0]][4:0];
  assign op_blk        = op_addr_reg[7:6];
  assign blk_protected = protect_bits[op_blk];
  assign flash_mode_control_reg      = {1'b0, protect_bits, 1'b0, self_mode_reg};
  assign flash_error_status_reg      = status_reg;
  assign flash_operation_command_reg = cmd_reg;
  assign read_data    = mem_reg[read_addr[7:0]];
  assign halt_release = release_reg;
  assign cpu_stalled  = (state_reg != fspc_pkg::FSPC_IDLE);
  assign irq_accept   = irq_request && !self_mode_reg && !cpu_stalled;
  assign pins_standby = self_mode_reg;

  // Blank scan over the addressed block; data compare of the addressed byte only
  always_comb begin
    mismatch  = 1'b0;
    not_blank = 1'b0;
    for (int i = 0; i < BLK_BYTES; i++) begin
      if (mem_reg[{op_blk, 6'(i)}] != fspc_pkg::BLANK_BYTE) begin
        not_blank = 1'b1;
      end
    end
    if (mem_reg[op_addr_reg] != op_data_reg) begin
      mismatch = 1'b1;
    end
  end

  always_comb begin
    self_mode_next = self_mode_reg;
    cmd_next       = cmd_reg;
    if (mode_we) begin
      self_mode_next = store.data[fspc_pkg::MODE_SELF_BIT];
    end
    if (store.en && store.sel == fspc_pkg::REG_OP_CMD && state_reg == fspc_pkg::FSPC_IDLE) begin
      cmd_next = store.data;
    end
  end

  // Sequencer
  always_comb begin
    state_next   = state_reg;
    tmr_next     = tmr_reg;
    op_addr_next = op_addr_reg;
    op_data_next = op_data_reg;
    release_next = 1'b0;
    do_erase     = 1'b0;
    do_write     = 1'b0;
    status_next  = status_reg;
    if (store.en && store.sel == fspc_pkg::REG_ERR_STATUS) begin
      status_next = status_reg & store.data & 8'h07;
    end
    if (seq_error) begin
      status_next[fspc_pkg::ST_UNLOCK_ERR] = 1'b1;
    end
    case (state_reg)
      fspc_pkg::FSPC_IDLE: begin
        if (halt_exec && self_mode_reg) begin
          op_addr_next = flash_addr_pointer[7:0];
          op_data_next = flash_write_buffer;
          if (mode_we || cmd_reg == fspc_pkg::CMD_NONE) begin
            state_next = fspc_pkg::FSPC_ENTRY;
            // Two cycles of pipeline: release lands on the last allowed cycle
            tmr_next   = fspc_pkg::TMR_W'(fspc_pkg::CYC_ENTRY - 2);
          end else if (known_cmd(cmd_reg)) begin
            state_next = fspc_pkg::FSPC_RUN;
            tmr_next   = cmd_cycles(cmd_reg, verify_count) - fspc_pkg::TMR_W'(2);
          end else begin
            state_next = fspc_pkg::FSPC_DONE;
          end
        end
      end
      fspc_pkg::FSPC_ENTRY: begin
        if (tmr_reg == '0) begin
          state_next = fspc_pkg::FSPC_DONE;
        end else begin
          tmr_next = tmr_reg - fspc_pkg::TMR_W'(1);
        end
      end
      fspc_pkg::FSPC_RUN: begin
        if (tmr_reg == '0) begin
          state_next = fspc_pkg::FSPC_DONE;
          case (cmd_reg)
            fspc_pkg::CMD_VERIFY_BLK, fspc_pkg::CMD_VERIFY_BYTE: begin
              if (mismatch) status_next[fspc_pkg::ST_VERIFY_ERR] = 1'b1;
            end
            fspc_pkg::CMD_ERASE_BLK: begin
              if (blk_protected) begin
                status_next[fspc_pkg::ST_PROTECT_ERR] = 1'b1;
              end else begin
                do_erase = 1'b1;
              end
            end
            fspc_pkg::CMD_BLANK_CHK: begin
              if (not_blank) status_next[fspc_pkg::ST_VERIFY_ERR] = 1'b1;
            end
            fspc_pkg::CMD_BYTE_WRITE: begin
              if (blk_protected) begin
                status_next[fspc_pkg::ST_PROTECT_ERR] = 1'b1;
              end else begin
                do_write = 1'b1;
              end
            end
            default: state_next = fspc_pkg::FSPC_DONE;
          endcase
        end else begin
          tmr_next = tmr_reg - fspc_pkg::TMR_W'(1);
        end
      end
      fspc_pkg::FSPC_DONE: begin
        release_next = 1'b1;
        state_next   = fspc_pkg::FSPC_IDLE;
      end
      default: state_next = fspc_pkg::FSPC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      self_mode_reg <= 1'b0;
      status_reg    <= fspc_pkg::STATUS_RESET;
      cmd_reg       <= fspc_pkg::CMD_NONE;
      state_reg     <= fspc_pkg::FSPC_IDLE;
      tmr_reg       <= '0;
      op_addr_reg   <= 8'h00;
      op_data_reg   <= 8'h00;
      release_reg   <= 1'b0;
    end else begin
      self_mode_reg <= self_mode_next;
      status_reg    <= status_next;
      cmd_reg       <= cmd_next;
      state_reg     <= state_next;
      tmr_reg       <= tmr_next;
      op_addr_reg   <= op_addr_next;
      op_data_reg   <= op_data_next;
      release_reg   <= release_next;
    end
  end

  // Flash contents survive reset, as real cells do
  // erase fills block with blank byte
  generate
    for (genvar g = 0; g < 256; g++) begin : g_cell
      always_ff @(posedge core_clk) begin
        if (do_erase && op_blk == 2'(g / BLK_BYTES)) begin
          mem_reg[g] <= fspc_pkg::BLANK_BYTE;
        end else if (do_write && op_addr_reg == 8'(g)) begin
          mem_reg[g] <= op_data_reg;
        end
      end
    end
  endgenerate

  // Helper: cycles since a byte write launch; too long for a plain delay
  logic [fspc_pkg::TMR_W-1:0] wr_cnt_reg;
  logic [fspc_pkg::TMR_W-1:0] wr_cnt_next;

  always_comb begin
    wr_cnt_next = wr_cnt_reg;
    if (halt_release) begin
      wr_cnt_next = '0;
    end else if (wr_cnt_reg != '0) begin
      wr_cnt_next = wr_cnt_reg + fspc_pkg::TMR_W'(1);
    end
    if (state_reg == fspc_pkg::FSPC_IDLE && halt_exec && self_mode_reg && !mode_we
        && cmd_reg == fspc_pkg::CMD_BYTE_WRITE) begin
      wr_cnt_next = fspc_pkg::TMR_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_cnt_reg <= '0;
    end else begin
      wr_cnt_reg <= wr_cnt_next;
    end
  end

  sequence s_erase_start;
    state_reg == fspc_pkg::FSPC_IDLE && halt_exec && self_mode_reg && !mode_we
      && cmd_reg == fspc_pkg::CMD_ERASE_BLK;
  endsequence

  chk_halt_normal_idle: assert property (@(posedge core_clk) disable iff (rst)
    halt_exec && !self_mode_reg && state_reg == fspc_pkg::FSPC_IDLE |=> !cpu_stalled)
    else $error("HALT in normal mode started an operation");

  chk_irq_blocked: assert property (@(posedge core_clk) disable iff (rst)
    self_mode_reg |-> !irq_accept)
    else $error("interrupt accepted in self mode");

  chk_pins_standby: assert property (@(posedge core_clk) disable iff (rst)
    pins_standby == self_mode_reg)
    else $error("pins not in standby during self mode");

  chk_entry_release: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == fspc_pkg::FSPC_IDLE && halt_exec && self_mode_reg
      && (mode_we || cmd_reg == fspc_pkg::CMD_NONE) |-> ##[1:203] halt_release)
    else $error("entry HALT not released in time");

  chk_write_time: assert property (@(posedge core_clk) disable iff (rst)
    wr_cnt_reg != '0
      |-> halt_release == (wr_cnt_reg == fspc_pkg::TMR_W'(fspc_pkg::CYC_WRITE + 1)))
    else $error("byte write did not end at 150 us");

  chk_erase_busy: assert property (@(posedge core_clk) disable iff (rst)
    s_erase_start |=> cpu_stalled [*8])
    else $error("erase did not hold the CPU");

  chk_unlock_flag_set: assert property (@(posedge core_clk) disable iff (rst)
    seq_error |=> flash_error_status_reg[0])
    else $error("sequence error not flagged");

  chk_mode_guarded: assert property (@(posedge core_clk) disable iff (rst)
    !mode_we |=> $stable(self_mode_reg))
    else $error("mode changed without unlock");

  chk_reset_mode: assert property (@(posedge core_clk)
    rst |=> !self_mode_reg)
    else $error("mode bit not cleared by reset");
endmodule

// file: hdl/fspc_unlock.sv
// Unlock sequence checker guarding the mode control register
`timescale 1ns/1ps
module fspc_unlock (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire fspc_pkg::fspc_store_t store,
  output logic                    mode_we,
  output logic                    seq_error
);
  logic [1:0] step_reg;
  logic [1:0] step_next;
  logic [7:0] value_reg;
  logic [7:0] value_next;

  always_comb begin
    step_next  = step_reg;
    value_next = value_reg;
    mode_we    = 1'b0;
    seq_error  = 1'b0;
    if (store.en) begin
      step_next = 2'h0;
      case (step_reg)
        2'h0: begin
          if (store.sel == fspc_pkg::REG_UNLOCK_CMD && store.data == fspc_pkg::UNLOCK_KEY) begin
            step_next = 2'h1;
          end else if (store.sel == fspc_pkg::REG_UNLOCK_CMD
                       || store.sel == fspc_pkg::REG_MODE_CTRL) begin
            seq_error = 1'b1;
          end
        end
        2'h1: begin
          if (store.sel == fspc_pkg::REG_MODE_CTRL) begin
            step_next  = 2'h2;
            value_next = store.data;
          end else begin
            seq_error = 1'b1;
          end
        end
        2'h2: begin
          if (store.sel == fspc_pkg::REG_MODE_CTRL && store.data == ~value_reg) begin
            step_next = 2'h3;
          end else begin
            seq_error = 1'b1;
          end
        end
        2'h3: begin
          if (store.sel == fspc_pkg::REG_MODE_CTRL && store.data == value_reg) begin
            mode_we = 1'b1;
          end else begin
            seq_error = 1'b1;
          end
        end
        default: step_next = 2'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_reg  <= 2'h0;
      value_reg <= 8'h00;
    end else begin
      step_reg  <= step_next;
      value_reg <= value_next;
    end
  end

  // Commit only on the final mode store repeating the held value
  chk_unlock_commit_path: assert property (@(posedge core_clk) disable iff (rst)
    mode_we |-> store.en && store.sel == fspc_pkg::REG_MODE_CTRL
      && store.data == value_reg)
    else $error("mode write without matching final step");
endmodule

// file: inc/fspc_pkg.sv
// Package: constants and carriers for the flash self-programming controller
package fspc_pkg;
  // Register indices on the peripheral store port
  localparam logic [1:0] REG_UNLOCK_CMD  = 2'h0;
  localparam logic [1:0] REG_ERR_STATUS  = 2'h1;
  localparam logic [1:0] REG_MODE_CTRL   = 2'h2;
  localparam logic [1:0] REG_OP_CMD      = 2'h3;
  localparam logic [7:0] UNLOCK_KEY      = 8'hA5;
  localparam logic [7:0] BLANK_BYTE      = 8'hFF;
  localparam logic [7:0] CMD_NONE        = 8'h00;
  localparam logic [7:0] CMD_VERIFY_BLK  = 8'h01;
  localparam logic [7:0] CMD_VERIFY_BYTE = 8'h02;
  localparam logic [7:0] CMD_ERASE_BLK   = 8'h03;
  localparam logic [7:0] CMD_BLANK_CHK   = 8'h04;
  localparam logic [7:0] CMD_BYTE_WRITE  = 8'h05;
  localparam logic [15:0] PROTECT_ADDR   = 16'h0081;
  localparam int ST_UNLOCK_ERR  = 0;
  localparam int ST_VERIFY_ERR  = 1;
  localparam int ST_PROTECT_ERR = 2;
  localparam int MODE_SELF_BIT  = 0;
  localparam int PROT_LSB       = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int CLK_HZ = 20000000;
  // Durations in ns; T_ENTRY_EXTRA in cycles
  localparam int T_VERIFY_BLK_NS  = 6800000;
  localparam int T_VERIFY_BYTE_NS = 27000;
  localparam int T_ERASE_NS       = 8500000;
  localparam int T_BLANK_NS       = 480000;
  localparam int T_WRITE_NS       = 150000;
  localparam int T_ENTRY_NS       = 10000;
  localparam int T_ENTRY_EXTRA    = 2;
  localparam int PERIOD_NS        = 1000000000 / CLK_HZ;
  // Longest times round down
  localparam int CYC_VERIFY_BLK   = T_VERIFY_BLK_NS / PERIOD_NS;
  localparam int CYC_VERIFY_BYTE  = T_VERIFY_BYTE_NS / PERIOD_NS;
  localparam int CYC_ERASE        = T_ERASE_NS / PERIOD_NS;
  localparam int CYC_BLANK        = T_BLANK_NS / PERIOD_NS;
  localparam int CYC_WRITE        = T_WRITE_NS / PERIOD_NS;
  localparam int CYC_ENTRY        = T_ENTRY_NS / PERIOD_NS + T_ENTRY_EXTRA;
  localparam int TMR_W            = 20;

  typedef struct packed {
    logic        en;
    logic [1:0]  sel;
    logic [7:0]  data;
  } fspc_store_t;

  typedef struct packed {
    logic        req;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fspc_op_t;

  typedef enum logic [2:0] {
    FSPC_IDLE  = 3'b000,
    FSPC_ENTRY = 3'b001,
    FSPC_CHECK = 3'b010,
    FSPC_RUN   = 3'b011,
    FSPC_DONE  = 3'b100
  } fspc_state_t;
endpackage

// file: tb/fspc_cpu_model.sv
// CPU-side partner: peripheral stores, HALT, interrupt line and array reads
`timescale 1ns/1ps
module fspc_cpu_model (
  input  wire logic             core_clk,
  input  wire logic             halt_release,
  input  wire logic             cpu_stalled,
  input  wire logic [7:0]       read_data,
  output fspc_pkg::fspc_store_t store,
  output logic                  halt_exec,
  output logic                  irq_request,
  output logic [15:0]           flash_addr_pointer,
  output logic [7:0]            flash_write_buffer,
  output logic [7:0]            verify_count,
  output logic [15:0]           read_addr
);
  logic stall_seen;

  initial begin
    store = '0;
    halt_exec = 1'h0;
    irq_request = 1'h0;
    flash_addr_pointer = 16'h0000;
    flash_write_buffer = 8'h00;
    verify_count = 8'h01;
    read_addr = 16'h0000;
    stall_seen = 1'h0;
  end

  // Idle data inverted so a stale byte never looks like a store
  task automatic put(input logic [1:0] sel, input logic [7:0] data);
    @(negedge core_clk);
    store = '{en: 1'h1, sel: sel, data: data};
    @(negedge core_clk);
    store.en = 1'h0;
    store.data = ~data;
  endtask

  task automatic set_mode(input logic [7:0] v);
    put(fspc_pkg::REG_OP_CMD, fspc_pkg::CMD_NONE);
    put(fspc_pkg::REG_UNLOCK_CMD, fspc_pkg::UNLOCK_KEY);
    put(fspc_pkg::REG_MODE_CTRL, v);
    put(fspc_pkg::REG_MODE_CTRL, ~v);
    put(fspc_pkg::REG_MODE_CTRL, v);
  endtask

  task automatic halt(input int lim, output int n);
    @(negedge core_clk);
    halt_exec = 1'h1;
    n = 0;
    stall_seen = 1'h0;
    @(negedge core_clk);
    halt_exec = 1'h0;
    while (halt_release !== 1'h1 && n < lim) begin
      @(negedge core_clk);
      n++;
      if (n == 2) begin
        stall_seen = cpu_stalled;
      end
    end
  endtask

  // NOP and HALT, then 8 us settle (160 cycles at 50 ns)
  task automatic enter(output int n);
    set_mode(8'h01);
    halt(1000, n);
    repeat (160) @(negedge core_clk);
  endtask

  // high pointer bits 12 to 15 kept clear
  task automatic op(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] cnt, output int n);
    flash_addr_pointer = a & 16'h0FFF;
    flash_write_buffer = d;
    verify_count = cnt;
    put(fspc_pkg::REG_OP_CMD, cmd);
    halt(20000, n);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    read_addr = a;
    #1;
    d = read_data;
  endtask

  task automatic irq(input logic v);
    @(negedge core_clk);
    irq_request = v;
    #1;
  endtask
endmodule

// file: tb/tb_fspc_ctrl.sv
// Self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module tb_fspc_ctrl;
  logic                  core_clk = 1'h0;
  logic                  rst = 1'h1;
  fspc_pkg::fspc_store_t store;
  logic                  halt_exec, irq_request, halt_release, cpu_stalled;
  logic                  irq_accept, pins_standby;
  logic [15:0]           flash_addr_pointer, read_addr;
  logic [7:0]            flash_write_buffer, verify_count, read_data, d;
  logic [7:0]            mode_reg, status_reg, op_reg;
  int                    n_fail = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  int                    n;

  // core clock far above 1 MHz
  always #25 core_clk = ~core_clk;

  fspc_cpu_model u_fspc_cpu_model (
    .core_clk(core_clk), .halt_release(halt_release), .cpu_stalled(cpu_stalled),
    .read_data(read_data), .store(store), .halt_exec(halt_exec),
    .irq_request(irq_request), .flash_addr_pointer(flash_addr_pointer),
    .flash_write_buffer(flash_write_buffer), .verify_count(verify_count),
    .read_addr(read_addr));

  fspc_ctrl u_fspc_ctrl (
    .core_clk(core_clk), .rst(rst), .store(store),
    .flash_addr_pointer(flash_addr_pointer), .flash_write_buffer(flash_write_buffer),
    .verify_count(verify_count), .halt_exec(halt_exec), .irq_request(irq_request),
    .read_addr(read_addr), .read_data(read_data), .halt_release(halt_release),
    .cpu_stalled(cpu_stalled), .irq_accept(irq_accept), .pins_standby(pins_standby),
    .flash_mode_control_reg(mode_reg), .flash_error_status_reg(status_reg),
    .flash_operation_command_reg(op_reg));

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_int(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset mid-run; flash cells keep their contents
  task automatic pulse_reset();
    @(negedge core_clk);
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
  endtask

  // Longest path is about 25k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    check1("self mode", 1'h0, mode_reg[fspc_pkg::MODE_SELF_BIT]);
    check8("status", fspc_pkg::STATUS_RESET, status_reg);
    check8("op command", fspc_pkg::CMD_NONE, op_reg);
    check1("pins", 1'h0, pins_standby);
    u_fspc_cpu_model.halt(50, n);
    check_int("normal halt", 50, n);
    check1("normal stall", 1'h0, u_fspc_cpu_model.stall_seen);
    u_fspc_cpu_model.irq(1'h1);
    check1("irq normal", 1'h1, irq_accept);
    $display("test normal mode done");
    u_fspc_cpu_model.put(fspc_pkg::REG_UNLOCK_CMD, fspc_pkg::UNLOCK_KEY);
    u_fspc_cpu_model.put(fspc_pkg::REG_MODE_CTRL, 8'h01);
    u_fspc_cpu_model.put(fspc_pkg::REG_MODE_CTRL, 8'h01);
    check1("seq error", 1'h1, status_reg[fspc_pkg::ST_UNLOCK_ERR]);
    check1("mode kept", 1'h0, mode_reg[0]);
    u_fspc_cpu_model.put(fspc_pkg::REG_ERR_STATUS, 8'h00);
    check8("status clear", 8'h00, status_reg);
    u_fspc_cpu_model.put(fspc_pkg::REG_MODE_CTRL, 8'h01);
    check1("stray store", 1'h1, status_reg[0]);
    check1("mode kept", 1'h0, mode_reg[0]);
    u_fspc_cpu_model.put(fspc_pkg::REG_ERR_STATUS, 8'h00);
    $display("test unlock errors done");
    u_fspc_cpu_model.enter(n);
    check_int("entry release", fspc_pkg::CYC_ENTRY, n);
    check1("self mode", 1'h1, mode_reg[0]);
    check1("pins", 1'h1, pins_standby);
    check1("irq self", 1'h0, irq_accept);
    u_fspc_cpu_model.op(fspc_pkg::CMD_BYTE_WRITE, fspc_pkg::PROTECT_ADDR, 8'h00, 8'h01, n);
    check_int("write time", fspc_pkg::CYC_WRITE, n);
    check8("mode reg", 8'h01, mode_reg);
    u_fspc_cpu_model.op(fspc_pkg::CMD_BYTE_WRITE, 16'h0040, 8'h5A, 8'h01, n);
    check1("stalled", 1'h1, u_fspc_cpu_model.stall_seen);
    u_fspc_cpu_model.rd(16'h0040, d);
    check8("written byte", 8'h5A, d);
    $display("test entry and write done");
    u_fspc_cpu_model.op(fspc_pkg::CMD_VERIFY_BYTE, 16'h0040, 8'h5A, 8'h01, n);
    check_int("verify time", fspc_pkg::CYC_VERIFY_BYTE, n);
    check1("verify ok", 1'h0, status_reg[fspc_pkg::ST_VERIFY_ERR]);
    u_fspc_cpu_model.op(fspc_pkg::CMD_VERIFY_BYTE, 16'h0040, 8'h00, 8'h00, n);
    check_int("verify zero count", fspc_pkg::CYC_VERIFY_BYTE, n);
    check1("verify bad", 1'h1, status_reg[fspc_pkg::ST_VERIFY_ERR]);
    u_fspc_cpu_model.put(fspc_pkg::REG_ERR_STATUS, 8'h00);
    u_fspc_cpu_model.op(fspc_pkg::CMD_BLANK_CHK, 16'h0040, 8'h00, 8'h01, n);
    check_int("blank time", fspc_pkg::CYC_BLANK, n);
    check1("not blank", 1'h1, status_reg[fspc_pkg::ST_VERIFY_ERR]);
    u_fspc_cpu_model.put(fspc_pkg::REG_ERR_STATUS, 8'h00);
    $display("test verify and blank done");
    u_fspc_cpu_model.op(fspc_pkg::CMD_BYTE_WRITE, fspc_pkg::PROTECT_ADDR, 8'h02, 8'h01, n);
    check8("mode reg", 8'h09, mode_reg);
    u_fspc_cpu_model.op(fspc_pkg::CMD_BYTE_WRITE, 16'h0040, 8'h33, 8'h01, n);
    u_fspc_cpu_model.rd(16'h0040, d);
    check8("protected byte", 8'h5A, d);
    check1("protect error", 1'h1, status_reg[fspc_pkg::ST_PROTECT_ERR]);
    u_fspc_cpu_model.put(fspc_pkg::REG_ERR_STATUS, 8'h00);
    u_fspc_cpu_model.op(8'h07, 16'h0040, 8'h00, 8'h01, n);
    check_int("unknown code", 1, n);
    $display("test protect and codes done");
    u_fspc_cpu_model.set_mode(8'h00);
    check1("normal mode", 1'h0, mode_reg[0]);
    check1("pins", 1'h0, pins_standby);
    check1("irq after exit", 1'h1, irq_accept);
    u_fspc_cpu_model.halt(50, n);
    check_int("halt after exit", 50, n);
    $display("test exit done");
    u_fspc_cpu_model.enter(n);
    check_int("reentry release", fspc_pkg::CYC_ENTRY, n);
    u_fspc_cpu_model.put(fspc_pkg::REG_UNLOCK_CMD, 8'h00);
    check1("stray key", 1'h1, status_reg[fspc_pkg::ST_UNLOCK_ERR]);
    // single erase attempt, cut short by reset
    u_fspc_cpu_model.put(fspc_pkg::REG_OP_CMD, fspc_pkg::CMD_ERASE_BLK);
    u_fspc_cpu_model.halt(20, n);
    check_int("erase busy", 20, n);
    check1("erase stall", 1'h1, cpu_stalled);
    pulse_reset();
    check1("mode after reset", 1'h0, mode_reg[0]);
    check1("stall after reset", 1'h0, cpu_stalled);
    check8("status after reset", fspc_pkg::STATUS_RESET, status_reg);
    check8("op after reset", fspc_pkg::CMD_NONE, op_reg);
    u_fspc_cpu_model.enter(n);
    u_fspc_cpu_model.put(fspc_pkg::REG_OP_CMD, fspc_pkg::CMD_VERIFY_BLK);
    u_fspc_cpu_model.halt(20, n);
    check_int("block verify busy", 20, n);
    check1("verify stall", 1'h1, cpu_stalled);
    pulse_reset();
    check1("pins after reset", 1'h0, pins_standby);
    $display("test long commands and reset done");
    summarize();
  end
endmodule
